//--- hdl/deed_pkg.sv
package deed_pkg;
	// ========================================
	// Widths and counts
	localparam int ADDR_W = 20;
	localparam int PERF_W = 32;
	localparam int PROF_TIME_W = 32;
	localparam int PASS_W = 16;
	localparam logic [15:0] PASS_MAX = 16'hffff;
	localparam int TRACE_DEPTH = 4194304;
	localparam int TRACE_W = 23;
	localparam int TASK_ID_W = 8;
	localparam int NUM_TASK_RANGES = 4;
	// ========================================
	// Event indices, one sticky flag each
	localparam int EV_STACK = 0;
	localparam int EV_PERF = 1;
	localparam int EV_PROF = 2;
	localparam int EV_TRACE = 3;
	localparam int EV_TASK_STACK = 4;
	localparam int EV_DISPATCH = 5;
	localparam int NUM_EV = 6;
	// ========================================
	// Start and stop sequencer states
	typedef enum logic [2:0] {
		DEED_RUN_IDLE,
		DEED_RUN_PRE,
		DEED_RUN_USER,
		DEED_RUN_POST
	} deed_run_state_t;
endpackage

//--- hdl/deed_range_check.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Range comparator
// Gives a registered out-of-range flag for one pointer against two windows.
module deed_range_check #(
	parameter int ADDR_W = 20
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic reset_in,
	// Pointer and windows
	input wire logic [ADDR_W-1:0] ptr_in,
	input wire logic [ADDR_W-1:0] lo0_in,
	input wire logic [ADDR_W-1:0] hi0_in,
	input wire logic [ADDR_W-1:0] lo1_in,
	input wire logic [ADDR_W-1:0] hi1_in,
	// Result
	output logic outside_out
);
	always_ff @(posedge mclk_in or posedge reset_in)
	begin
		if (reset_in)
			outside_out <= 1'b0;
		else
			outside_out <= !(((ptr_in >= lo0_in) && (ptr_in <= hi0_in))
				|| ((ptr_in >= lo1_in) && (ptr_in <= hi1_in)));
	end
endmodule
`default_nettype wire

//--- hdl/deed_detector.sv
`timescale 1ns/1ps
`default_nettype none
module deed_detector #(
	parameter int ADDR_W = deed_pkg::ADDR_W,
	parameter int PERF_W = deed_pkg::PERF_W,
	parameter int PROF_TIME_W = deed_pkg::PROF_TIME_W,
	parameter int TRACE_W = deed_pkg::TRACE_W,
	parameter int TRACE_DEPTH = deed_pkg::TRACE_DEPTH,
	parameter int TASK_ID_W = deed_pkg::TASK_ID_W,
	parameter int NTR = deed_pkg::NUM_TASK_RANGES
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic reset_in,
	// Core stack pointers and flow events
	input wire logic [ADDR_W-1:0] user_stack_pointer_in,
	input wire logic [ADDR_W-1:0] interrupt_stack_pointer_in,
	input wire logic irq_take_in,
	input wire logic irq_return_in,
	input wire logic sub_call_in,
	input wire logic sub_return_in,
	// Stack range configuration
	input wire logic ranges_loaded_in,
	input wire logic [ADDR_W-1:0] ustack_lo_in,
	input wire logic [ADDR_W-1:0] ustack_hi_in,
	input wire logic [ADDR_W-1:0] istack_lo_in,
	input wire logic [ADDR_W-1:0] istack_hi_in,
	// Performance section timer
	input wire logic perf_run_in,
	input wire logic perf_clear_in,
	// Profile measurement
	input wire logic prof_run_in,
	input wire logic prof_pass_in,
	input wire logic prof_clear_in,
	// Trace capture
	input wire logic trace_store_in,
	input wire logic trace_clear_in,
	// Operating system awareness
	input wire logic os_loaded_in,
	input wire logic [TASK_ID_W-1:0] cur_task_in,
	input wire logic bus_write_in,
	input wire logic [ADDR_W-1:0] bus_addr_in,
	input wire logic [NTR*TASK_ID_W-1:0] task_ids_in,
	input wire logic [NTR*ADDR_W-1:0] task_lo_in,
	input wire logic [NTR*ADDR_W-1:0] task_hi_in,
	input wire logic [NTR-1:0] task_valid_in,
	input wire logic dispatch_in,
	// Event routing enables and flag clearing
	input wire logic [deed_pkg::NUM_EV-1:0] warn_en_in,
	input wire logic [deed_pkg::NUM_EV-1:0] break_en_in,
	input wire logic [deed_pkg::NUM_EV-1:0] trace_en_in,
	input wire logic [deed_pkg::NUM_EV-1:0] flag_clear_in,
	// Start and stop control
	input wire logic go_in,
	input wire logic halt_in,
	input wire logic pre_en_in,
	input wire logic post_en_in,
	input wire logic routine_done_in,
	// Event outputs
	output logic [deed_pkg::NUM_EV-1:0] flags_out,
	output logic warn_out,
	output logic break_out,
	output logic trace_point_out,
	output logic perf_overflow_mark_out,
	output logic [PERF_W-1:0] perf_time_out,
	output logic [deed_pkg::PASS_W-1:0] prof_passes_out,
	// Start and stop outputs
	output logic run_pre_out,
	output logic run_user_out,
	output logic run_post_out
);
	logic usp_out_r;
	logic isp_out_r;
	logic [deed_pkg::NUM_EV-1:0] ev_nxt;
	logic [deed_pkg::NUM_EV-1:0] tp_route_nxt;
	logic [PROF_TIME_W-1:0] prof_time_r;
	logic [TRACE_W-1:0] trace_fill_r;
	logic task_viol_nxt;
	deed_pkg::deed_run_state_t state_r;

	// ========================================
	// Stack pointer checking
	// user pointer compare
	deed_range_check #(.ADDR_W(ADDR_W)) u_usp (
		.mclk_in(mclk_in),
		.reset_in(reset_in),
		.ptr_in(user_stack_pointer_in),
		.lo0_in(ustack_lo_in),
		.hi0_in(ustack_hi_in),
		.lo1_in(istack_lo_in),
		.hi1_in(istack_hi_in),
		.outside_out(usp_out_r)
	);
	deed_range_check #(.ADDR_W(ADDR_W)) u_isp (
		.mclk_in(mclk_in),
		.reset_in(reset_in),
		.ptr_in(interrupt_stack_pointer_in),
		.lo0_in(ustack_lo_in),
		.hi0_in(ustack_hi_in),
		.lo1_in(istack_lo_in),
		.hi1_in(istack_hi_in),
		.outside_out(isp_out_r)
	);

	// ========================================
	// Measurement counters
	// section timer saturates
	always_ff @(posedge mclk_in or posedge reset_in)
	begin
		if (reset_in)
			perf_time_out <= '0;
		else if (perf_clear_in)
			perf_time_out <= '0;
		else if (perf_run_in && (perf_time_out != '1))
			perf_time_out <= perf_time_out + 1'b1;
	end

	always_ff @(posedge mclk_in or posedge reset_in)
	begin
		if (reset_in)
			perf_overflow_mark_out <= 1'b0;
		else if (perf_run_in && (perf_time_out == '1))
			perf_overflow_mark_out <= 1'b1;
		else if (perf_clear_in)
			perf_overflow_mark_out <= 1'b0;
	end

	always_ff @(posedge mclk_in or posedge reset_in)
	begin
		if (reset_in)
			prof_time_r <= '0;
		else if (prof_clear_in)
			prof_time_r <= '0;
		else if (prof_run_in && (prof_time_r != '1))
			prof_time_r <= prof_time_r + 1'b1;
	end

	always_ff @(posedge mclk_in or posedge reset_in)
	begin
		if (reset_in)
			prof_passes_out <= '0;
		else if (prof_clear_in)
			prof_passes_out <= '0;
		else if (prof_pass_in && (prof_passes_out != deed_pkg::PASS_MAX))
			prof_passes_out <= prof_passes_out + 1'b1;
	end

	// Fill saturates at capacity, so TRACE_W must hold the full depth itself.
	always_ff @(posedge mclk_in or posedge reset_in)
	begin
		if (reset_in)
			trace_fill_r <= '0;
		else if (trace_clear_in)
			trace_fill_r <= '0;
		else if (trace_store_in && (trace_fill_r != TRACE_W'(TRACE_DEPTH)))
			trace_fill_r <= trace_fill_r + 1'b1;
	end

	// ========================================
	// Task stack ownership
	function automatic logic in_range(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] lo, input logic [ADDR_W-1:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	always_comb
	begin
		task_viol_nxt = 1'b0;
		for (int i = 0; i < NTR; i++)
		begin
			if (task_valid_in[i] && bus_write_in
				&& in_range(bus_addr_in, task_lo_in[i*ADDR_W +: ADDR_W],
					task_hi_in[i*ADDR_W +: ADDR_W])
				&& (task_ids_in[i*TASK_ID_W +: TASK_ID_W] != cur_task_in))
				task_viol_nxt = 1'b1;
		end
	end

	// ========================================
	// Event detection
	always_comb
	begin
		ev_nxt = '0;
		// every-cycle compare, which also covers interrupt and call edges.
		ev_nxt[deed_pkg::EV_STACK] = ranges_loaded_in && (usp_out_r || isp_out_r);
		ev_nxt[deed_pkg::EV_PERF] = perf_run_in && (perf_time_out == '1);
		ev_nxt[deed_pkg::EV_PROF] = (prof_run_in && (prof_time_r == '1))
			|| (prof_pass_in && (prof_passes_out == deed_pkg::PASS_MAX));
		ev_nxt[deed_pkg::EV_TRACE] = trace_store_in
			&& (trace_fill_r == TRACE_W'(TRACE_DEPTH));
		ev_nxt[deed_pkg::EV_TASK_STACK] = os_loaded_in && ranges_loaded_in && task_viol_nxt;
		ev_nxt[deed_pkg::EV_DISPATCH] = os_loaded_in && dispatch_in;
		// Trace memory has no trace-point route, so its enable there is ignored.
		tp_route_nxt = ev_nxt & trace_en_in;
		tp_route_nxt[deed_pkg::EV_TRACE] = 1'b0;
	end

	// Set wins over a clear in the same cycle so no event is lost.
	// sticky flags
	always_ff @(posedge mclk_in or posedge reset_in)
	begin
		if (reset_in)
			flags_out <= '0;
		else
			flags_out <= (flags_out & ~flag_clear_in) | ev_nxt;
	end

	always_ff @(posedge mclk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			warn_out <= 1'b0;
			break_out <= 1'b0;
			trace_point_out <= 1'b0;
		end
		else
		begin
			warn_out <= |(ev_nxt & warn_en_in);
			break_out <= |(ev_nxt & break_en_in) && (state_r == deed_pkg::DEED_RUN_USER);
			trace_point_out <= |tp_route_nxt && (state_r == deed_pkg::DEED_RUN_USER);
		end
	end

	// ========================================
	// Start and stop sequencing
	// pre and post routines
	always_ff @(posedge mclk_in or posedge reset_in)
	begin
		if (reset_in)
			state_r <= deed_pkg::DEED_RUN_IDLE;
		else
		begin
			case (state_r)
				deed_pkg::DEED_RUN_IDLE:
					if (go_in)
						state_r <= pre_en_in ? deed_pkg::DEED_RUN_PRE : deed_pkg::DEED_RUN_USER;
				deed_pkg::DEED_RUN_PRE:
					if (routine_done_in)
						state_r <= deed_pkg::DEED_RUN_USER;
				deed_pkg::DEED_RUN_USER:
					if (halt_in)
						state_r <= post_en_in ? deed_pkg::DEED_RUN_POST : deed_pkg::DEED_RUN_IDLE;
				deed_pkg::DEED_RUN_POST:
					if (routine_done_in)
						state_r <= deed_pkg::DEED_RUN_IDLE;
				default:
					state_r <= deed_pkg::DEED_RUN_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			run_pre_out <= 1'b0;
			run_user_out <= 1'b0;
			run_post_out <= 1'b0;
		end
		else
		begin
			run_pre_out <= (state_r == deed_pkg::DEED_RUN_IDLE) ? (go_in && pre_en_in)
				: ((state_r == deed_pkg::DEED_RUN_PRE) && !routine_done_in);
			run_user_out <= (state_r == deed_pkg::DEED_RUN_USER) ? !halt_in
				: (((state_r == deed_pkg::DEED_RUN_PRE) && routine_done_in)
				|| ((state_r == deed_pkg::DEED_RUN_IDLE) && go_in && !pre_en_in));
			run_post_out <= (state_r == deed_pkg::DEED_RUN_USER) ? (halt_in && post_en_in)
				: ((state_r == deed_pkg::DEED_RUN_POST) && !routine_done_in);
		end
	end
endmodule
`default_nettype wire

//--- testbench/deed_detector_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Port checker
module deed_detector_chk (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic reset_in,
	// Watched inputs
	input wire logic ranges_loaded_in,
	input wire logic os_loaded_in,
	input wire logic dispatch_in,
	input wire logic go_in,
	input wire logic halt_in,
	input wire logic pre_en_in,
	input wire logic post_en_in,
	input wire logic routine_done_in,
	input wire logic [deed_pkg::NUM_EV-1:0] flag_clear_in,
	// Watched outputs
	input wire logic [deed_pkg::NUM_EV-1:0] flags_out,
	input wire logic break_out,
	input wire logic run_pre_out,
	input wire logic run_user_out,
	input wire logic run_post_out
);
	default clocking @(posedge mclk_in);
	endclocking
	default disable iff (reset_in);
	stack_needs_load_a: assert property ($rose(flags_out[0]) |-> $past(ranges_loaded_in))
		else $error("stack flag without ranges");
	dispatch_cause_a: assert property ($rose(flags_out[5]) |-> $past(dispatch_in && os_loaded_in))
		else $error("dispatch flag without cause");
	flags_sticky_a: assert property (1'b1 |=> ($past(flags_out & ~flag_clear_in) & ~flags_out) == 6'h00)
		else $error("flag dropped without clear");
	break_in_user_a: assert property (break_out |-> run_user_out || $past(run_user_out))
		else $error("break outside user run");
	run_onehot_a: assert property ($onehot0({run_pre_out, run_user_out, run_post_out}))
		else $error("run states overlap");
	pre_start_a: assert property (go_in && pre_en_in && !(run_pre_out || run_user_out || run_post_out)
		|=> run_pre_out) else $error("start routine missing");
	pre_to_user_a: assert property (run_pre_out && routine_done_in |=> run_user_out)
		else $error("user run missing");
	halt_to_post_a: assert property (run_user_out && halt_in && post_en_in |=> run_post_out)
		else $error("stop routine missing");
endmodule
bind deed_detector deed_detector_chk u_chk (.mclk_in, .reset_in, .ranges_loaded_in, .os_loaded_in,
	.dispatch_in, .go_in, .halt_in, .pre_en_in, .post_en_in, .routine_done_in, .flag_clear_in,
	.flags_out, .break_out, .run_pre_out, .run_user_out, .run_post_out);
`default_nettype wire

//--- testbench/deed_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Target core model
module deed_core_model #(
	parameter int DELAY = 3
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic reset_in,
	// Routine requests
	input wire logic run_pre_in,
	input wire logic run_post_in,
	// Routine completion
	output logic routine_done_out
);
	logic [3:0] cnt_r;
	// work stack apart.
	// The routine works in RAM the user program never uses, so no user pointer moves.
	// routine completion.
	always_ff @(posedge mclk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			cnt_r <= 4'h0;
			routine_done_out <= 1'b0;
		end
		else
		begin
			cnt_r <= (run_pre_in || run_post_in) ? cnt_r + 4'h1 : 4'h0;
			routine_done_out <= (cnt_r == 4'(DELAY - 1));
		end
	end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Detector testbench
module testbench;
	logic mclk_in = 1'b0, reset_in = 1'b1, irq_take_in = 1'b0, irq_return_in = 1'b0;
	logic sub_call_in = 1'b0, sub_return_in = 1'b0, ranges_loaded_in = 1'b0, perf_run_in = 1'b0;
	logic perf_clear_in = 1'b0, prof_run_in = 1'b0, prof_pass_in = 1'b0, prof_clear_in = 1'b0;
	logic trace_store_in = 1'b0, trace_clear_in = 1'b0, os_loaded_in = 1'b0, bus_write_in = 1'b0;
	logic dispatch_in = 1'b0, go_in = 1'b0, halt_in = 1'b0, pre_en_in = 1'b1, post_en_in = 1'b1;
	logic [19:0] user_stack_pointer_in = 20'h00180, interrupt_stack_pointer_in = 20'h00480;
	logic [19:0] ustack_lo_in = 20'h00100, ustack_hi_in = 20'h001ff, bus_addr_in = 20'h00610;
	logic [19:0] istack_lo_in = 20'h00400, istack_hi_in = 20'h004ff;
	logic [7:0] cur_task_in = 8'h02;
	logic [31:0] task_ids_in = 32'h00000001;
	logic [79:0] task_lo_in = 80'h00600, task_hi_in = 80'h006ff;
	logic [3:0] task_valid_in = 4'h1;
	logic [5:0] warn_en_in = 6'h3f, break_en_in = 6'h3f, trace_en_in = 6'h3f, flag_clear_in = 6'h00;
	logic [5:0] flags_out;
	logic warn_out, break_out, trace_point_out, perf_overflow_mark_out, routine_done_in;
	logic run_pre_out, run_user_out, run_post_out;
	logic [3:0] perf_time_out;
	logic [15:0] prof_passes_out;
	int fails = 0;
	int samples_checked = 0;
	// A narrow timer and short trace depth keep the timer and trace overflow runs brief.
	deed_detector #(.PERF_W(4), .TRACE_W(4), .TRACE_DEPTH(8)) u_dut (.*);
	deed_core_model u_core (.mclk_in, .reset_in, .run_pre_in(run_pre_out),
		.run_post_in(run_post_out), .routine_done_out(routine_done_in));
	initial
	begin
		forever #5 mclk_in = ~mclk_in;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_in);
	endtask
	task automatic look(input int n);
		tick(n);
		@(negedge mclk_in);
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish;
		if (fails == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		#900000;
		fails++;
		tally_and_finish();
	end
	initial
	begin
		tick(4);
		reset_in <= 1'b0;
		user_stack_pointer_in <= 20'h00200;
		look(5);
		chk("stack_unloaded", 16'h0, flags_out[0]);
		tick(1);
		ranges_loaded_in <= 1'b1;
		look(4);
		chk("stack_user", 16'h1, flags_out[0]);
		tick(1);
		user_stack_pointer_in <= 20'h001ff;
		tick(3);
		flag_clear_in <= 6'h01;
		tick(1);
		flag_clear_in <= 6'h00;
		look(1);
		chk("stack_clear", 16'h0, flags_out[0]);
		tick(1);
		interrupt_stack_pointer_in <= 20'h003ff;
		irq_take_in <= 1'b1;
		tick(1);
		irq_take_in <= 1'b0;
		interrupt_stack_pointer_in <= 20'h00400;
		look(3);
		chk("stack_irq", 16'h1, flags_out[0]);
		tick(1);
		flag_clear_in <= 6'h01;
		user_stack_pointer_in <= 20'h000ff;
		sub_call_in <= 1'b1;
		tick(1);
		flag_clear_in <= 6'h00;
		sub_call_in <= 1'b0;
		user_stack_pointer_in <= 20'h001ff;
		look(3);
		chk("stack_call", 16'h1, flags_out[0]);
		tick(1);
		os_loaded_in <= 1'b1;
		go_in <= 1'b1;
		tick(1);
		go_in <= 1'b0;
		look(1);
		chk("run_pre", 16'h1, run_pre_out);
		look(6);
		chk("run_user", 16'h1, run_user_out);
		tick(1);
		dispatch_in <= 1'b1;
		tick(1);
		dispatch_in <= 1'b0;
		look(0);
		chk("break_dispatch", 16'h1, break_out);
		chk("warn_dispatch", 16'h1, warn_out);
		chk("tp_dispatch", 16'h1, trace_point_out);
		chk("dispatch_flag", 16'h1, flags_out[5]);
		look(2);
		chk("break_pulse", 16'h0, break_out);
		tick(1);
		break_en_in <= 6'h1f;
		dispatch_in <= 1'b1;
		tick(1);
		dispatch_in <= 1'b0;
		look(0);
		chk("break_masked", 16'h0, break_out);
		chk("warn_kept", 16'h1, warn_out);
		chk("tp_kept", 16'h1, trace_point_out);
		tick(1);
		halt_in <= 1'b1;
		tick(1);
		halt_in <= 1'b0;
		look(8);
		chk("run_idle", 16'h0, {run_pre_out, run_user_out, run_post_out});
		tick(1);
		bus_write_in <= 1'b1;
		tick(1);
		bus_write_in <= 1'b0;
		look(3);
		chk("task_stack", 16'h1, flags_out[4]);
		tick(1);
		trace_store_in <= 1'b1;
		tick(8);
		trace_store_in <= 1'b0;
		look(2);
		chk("trace_full", 16'h0, flags_out[3]);
		tick(1);
		trace_store_in <= 1'b1;
		tick(2);
		trace_store_in <= 1'b0;
		look(2);
		chk("trace_over", 16'h1, flags_out[3]);
		tick(1);
		perf_run_in <= 1'b1;
		look(14);
		chk("perf_early", 16'h0, flags_out[1]);
		look(6);
		chk("perf_over", 16'h1, flags_out[1]);
		chk("perf_mark", 16'h1, perf_overflow_mark_out);
		chk("perf_time", 16'hf, perf_time_out);
		tick(1);
		perf_run_in <= 1'b0;
		perf_clear_in <= 1'b1;
		tick(1);
		perf_clear_in <= 1'b0;
		look(1);
		chk("perf_cleared", 16'h0, {perf_overflow_mark_out, perf_time_out});
		tick(1);
		prof_run_in <= 1'b1;
		prof_pass_in <= 1'b1;
		tick(65535);
		prof_pass_in <= 1'b0;
		look(2);
		chk("prof_full", 16'h0, flags_out[2]);
		chk("prof_count", 16'hffff, prof_passes_out);
		tick(1);
		prof_pass_in <= 1'b1;
		tick(1);
		prof_pass_in <= 1'b0;
		look(2);
		chk("prof_over", 16'h1, flags_out[2]);
		tally_and_finish();
	end
endmodule
`default_nettype wire
